// ==== sarc_ctrl.sv ====
// sarc_ctrl: control side of a 12-bit successive-approximation converter
// assumes analog levels arrive as 12-bit digitized values, inputs synchronous
//
// How it works
// RULE1: sixteen entry control and result buffer
// RULE2: full scale above upper, zero below lower
// RULE3: channel and references taken per entry
// RULE4: core powered only while power bit set
// RULE5: most configuration locked while enabled
// RULE6: no conversion without conversion enable
// RULE7: divided clock times conversion and sampling
// RULE8: overall clock division from 1 to 32
// RULE9: four selectable conversion clock sources
// RULE10: software keeps chosen clock running
// RULE11: sixteen channels, twelve pins, four internal
// RULE12: multiplexer breaks before it makes
// RULE13: analog pin select disables digital buffers
// RULE14: vector encodes highest of 18 sources
// RULE15: four single and sequence conversion modes
// RULE16: start by software bit or timers
// RULE17: start on trigger rising edge
// RULE18: 8/10/12 bits take 9/11/13 clocks
// RULE19: result right-justified, upper bits zero
// RULE20: predivider then divider, ratios multiply
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/10ps
module sarc_ctrl (
  input wire logic clk, // 250 MHz clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [sarc_pkg::DW-1:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [sarc_pkg::DW-1:0] rdata_reg, // read data, cycle after rd
  input wire logic [3:0] src_tick, // subsystem, main, aux, module osc ticks
  input wire logic [2:0] timer_trig, // timer trigger levels
  input wire logic [sarc_pkg::NCH*sarc_pkg::RW-1:0] ana_in, // channel levels
  input wire logic [sarc_pkg::RW-1:0] ref_pos_int, // internal upper ref
  input wire logic [sarc_pkg::RW-1:0] ref_pos_ext, // external upper ref
  input wire logic [sarc_pkg::RW-1:0] ref_neg_ext, // external lower ref
  output logic core_power_reg, // converter core power
  output logic [3:0] mux_channel_reg, // multiplexer channel
  output logic mux_connect_reg, // multiplexer switch closed
  output logic sampling_reg, // sample phase active
  output logic [sarc_pkg::NPIN-1:0] port_dig_disable_reg, // pin digital buffers off
  output logic busy_reg // conversion in progress
);
  import sarc_pkg::*;
  logic [15:0] ctl_a_reg;
  logic [15:0] ctl_b_reg;
  logic [3:0] start_reg;
  logic [7:0] mctl_reg [NENT];
  logic [RW-1:0] mem_reg [NENT];
  logic [NENT-1:0] flag_reg;
  logic ov_reg;
  logic tov_reg;
  sarc_state_t state_reg;
  logic [3:0] ptr_reg;
  logic done_lock_reg;
  logic trig_prev_reg;
  logic [6:0] samp_cnt_reg;
  logic [3:0] conv_cnt_reg;
  logic [RW-1:0] code_reg;
  logic [RW-1:0] hold_reg;
  logic [RW-1:0] vrp_reg;
  logic [RW-1:0] vrm_reg;
  logic tick;
  logic enc;
  logic trig_lvl;
  logic trig_rise;
  logic start_go;
  logic pulse_mode;
  logic [3:0] nbits;
  logic [6:0] samp_len;
  logic [RW-1:0] cand;
  logic [23:0] prod;
  logic [23:0] lvl;
  logic [RW-1:0] code_next;
  logic [RW-1:0] result;
  logic conv_done;
  logic [3:0] want_ch;
  logic [5:0] vec;
  logic [3:0] ridx;
  logic cfg_open;
  sarc_mode_t mode;

  assign enc = ctl_a_reg[CA_ENC];
  assign cfg_open = !enc;
  assign pulse_mode = ctl_b_reg[CB_PULSE];
  assign mode = sarc_mode_t'(ctl_b_reg[CB_MODE +: 2]);
  assign ridx = addr[4:1];
  // RULE18 bits per resolution, one extra sync clock
  assign nbits = (ctl_b_reg[CB_RES +: 2] == 2'h0) ? 4'h8 :
                 (ctl_b_reg[CB_RES +: 2] == 2'h1) ? 4'hA : 4'hC;
  assign samp_len = SHT_MULT * {3'h0, ctl_a_reg[CA_SHT +: 4]} + SHT_MULT;

  // RULE7 one divided tick drives sampling and conversion
  sarc_clkdiv u_div (
    .clk(clk),
    .rst_b(rst_b),
    .run(state_reg != ST_IDLE),
    .src_tick(src_tick),
    .src_sel(ctl_b_reg[CB_SRC +: 2]),
    .prediv(ctl_b_reg[CB_PDIV]),
    .div(ctl_b_reg[CB_DIV +: 3]),
    .tick_reg(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // RULE16 software bit or timer as trigger
  always_comb begin
    unique case (ctl_b_reg[CB_TRIG +: 2])
      2'h0: trig_lvl = ctl_a_reg[CA_SC];
      2'h1: trig_lvl = timer_trig[0];
      2'h2: trig_lvl = timer_trig[1];
      2'h3: trig_lvl = timer_trig[2];
    endcase
  end
  // RULE17 rising edge starts
  assign trig_rise = trig_lvl && !trig_prev_reg;
  // RULE6 enable and power gate every start
  assign start_go = trig_rise && enc && ctl_a_reg[CA_ON] && !done_lock_reg && state_reg == ST_IDLE;

  // RULE3 channel from entry in use
  assign want_ch = mctl_reg[ptr_reg][ME_CH +: 4];
  // RULE2 successive approximation against entry references
  assign cand = code_reg | (MSB_TRIAL >> (conv_cnt_reg - 4'h1));
  assign prod = (vrp_reg > vrm_reg) ? (vrp_reg - vrm_reg) * cand : 24'h0;
  // scale by 4095, not 4096, so the top code lands exactly on the upper reference
  assign lvl = (hold_reg > vrm_reg) ? (hold_reg - vrm_reg) * FULL_SCALE : 24'h0;
  assign code_next = (lvl >= prod) ? cand : code_reg;
  assign conv_done = tick && state_reg == ST_CONVERT && conv_cnt_reg == nbits;
  // RULE19 right-justified code
  always_comb begin
    if (hold_reg >= vrp_reg) begin
      result = FULL_SCALE >> (4'hC - nbits);
    end else if (hold_reg <= vrm_reg) begin
      result = 12'h000;
    end else begin
      result = code_next >> (4'hC - nbits);
    end
  end

  // RULE14 highest pending of 18 sources
  always_comb begin
    vec = VEC_NONE;
    for (int i = NENT - 1; i >= 0; i--) begin
      if (flag_reg[i]) begin
        vec = VEC_MEM0 + 6'(2 * i);
      end
    end
    if (tov_reg) begin
      vec = VEC_TOV;
    end
    if (ov_reg) begin
      vec = VEC_OV;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE5 only enable and start bits open while enabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_a_reg <= REG_RST;
    end else begin
      if (wr && addr == ADDR_CTL_A) begin
        ctl_a_reg <= cfg_open ? wdata : ((ctl_a_reg & ~CA_OPEN_MASK) | (wdata & CA_OPEN_MASK));
      end else if (start_go && ctl_b_reg[CB_TRIG +: 2] == 2'h0) begin
        ctl_a_reg[CA_SC] <= 1'b0;
      end
    end
  end
  // RULE5 locked configuration
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_b_reg <= REG_RST;
      start_reg <= 4'h0;
    end else if (wr && cfg_open) begin
      if (addr == ADDR_CTL_B) begin
        ctl_b_reg <= wdata;
      end
      if (addr == ADDR_CTL_C) begin
        start_reg <= wdata[3:0];
      end
    end
  end
  // RULE1 sixteen control entries
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NENT; i++) begin
        mctl_reg[i] <= 8'h00;
      end
    end else if (wr && cfg_open && (addr & BLK_MASK) == ADDR_MCTL) begin
      mctl_reg[ridx] <= wdata[7:0];
    end
  end
  // RULE13 analog select turns digital buffers off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port_dig_disable_reg <= 12'h000;
    end else if (wr && addr == ADDR_PSEL) begin
      port_dig_disable_reg <= wdata[NPIN-1:0];
    end
  end
  // RULE4 core power follows its bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_power_reg <= 1'b0;
      busy_reg <= 1'b0;
      sampling_reg <= 1'b0;
    end else begin
      core_power_reg <= ctl_a_reg[CA_ON];
      busy_reg <= state_reg != ST_IDLE;
      sampling_reg <= state_reg == ST_SAMPLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE15 conversion sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      ptr_reg <= 4'h0;
      done_lock_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      samp_cnt_reg <= 7'h00;
      conv_cnt_reg <= 4'h0;
      code_reg <= 12'h000;
      vrp_reg <= 12'h000;
      vrm_reg <= 12'h000;
    end else begin
      trig_prev_reg <= trig_lvl;
      if (!enc) begin
        done_lock_reg <= 1'b0;
      end
      unique case (state_reg)
        ST_IDLE: begin
          if (!enc) begin
            ptr_reg <= start_reg;
          end
          if (start_go) begin
            state_reg <= ST_SAMPLE;
            samp_cnt_reg <= 7'h00;
            // RULE3 references from entry in use
            vrp_reg <= mctl_reg[ptr_reg][ME_REFP] ? ref_pos_ext : ref_pos_int;
            vrm_reg <= mctl_reg[ptr_reg][ME_REFN] ? ref_neg_ext : 12'h000;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            samp_cnt_reg <= samp_cnt_reg + 7'h01;
          end
          // RULE7 pulse mode counts divided clocks
          if (pulse_mode ? (tick && samp_cnt_reg == samp_len - 7'h01) : (!trig_lvl && tick)) begin
            state_reg <= ST_CONVERT;
            conv_cnt_reg <= 4'h0;
            code_reg <= 12'h000;
          end
        end
        ST_CONVERT: begin
          // RULE10 progress only on conversion clock ticks
          if (tick) begin
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
            if (conv_cnt_reg != 4'h0) begin
              code_reg <= code_next;
            end
          end
          if (conv_done) begin
            state_reg <= ST_IDLE;
            unique case (mode)
              M_SINGLE: begin
                done_lock_reg <= 1'b1;
              end
              M_REP_SINGLE: begin
                ptr_reg <= ptr_reg;
              end
              M_SEQ: begin
                ptr_reg <= mctl_reg[ptr_reg][ME_EOS] ? start_reg : ptr_reg + 4'h1;
                done_lock_reg <= mctl_reg[ptr_reg][ME_EOS];
              end
              M_REP_SEQ: begin
                ptr_reg <= mctl_reg[ptr_reg][ME_EOS] ? start_reg : ptr_reg + 4'h1;
              end
            endcase
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // RULE12 open switch before changing channel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mux_channel_reg <= 4'h0;
      mux_connect_reg <= 1'b0;
      hold_reg <= 12'h000;
    end else begin
      mux_connect_reg <= state_reg == ST_SAMPLE && mux_channel_reg == want_ch;
      if (!mux_connect_reg) begin
        mux_channel_reg <= want_ch;
      end
      // RULE11 one of sixteen channel levels
      if (mux_connect_reg) begin
        hold_reg <= ana_in[mux_channel_reg * RW +: RW];
      end
    end
  end

  // RULE1 results stored per entry, flags set wins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NENT; i++) begin
        mem_reg[i] <= 12'h000;
      end
      flag_reg <= 16'h0000;
      ov_reg <= 1'b0;
      tov_reg <= 1'b0;
    end else begin
      for (int i = 0; i < NENT; i++) begin
        if (conv_done && ptr_reg == 4'(i)) begin
          mem_reg[i] <= result;
          flag_reg[i] <= 1'b1;
        end else if ((wr && addr == ADDR_FLAG && wdata[i]) ||
                     (rd && (addr & BLK_MASK) == ADDR_MEM && ridx == 4'(i))) begin
          flag_reg[i] <= 1'b0;
        end
      end
      if (conv_done && flag_reg[ptr_reg]) begin
        ov_reg <= 1'b1;
      end else if (rd && addr == ADDR_VEC && vec == VEC_OV) begin
        ov_reg <= 1'b0;
      end
      if (trig_rise && state_reg != ST_IDLE) begin
        tov_reg <= 1'b1;
      end else if (rd && addr == ADDR_VEC && vec == VEC_TOV) begin
        tov_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RULE19 upper result bits read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= REG_RST;
    end else if (rd) begin
      if ((addr & BLK_MASK) == ADDR_MCTL) begin
        rdata_reg <= {8'h00, mctl_reg[ridx]};
      end else if ((addr & BLK_MASK) == ADDR_MEM) begin
        rdata_reg <= {4'h0, mem_reg[ridx]};
      end else begin
        unique case (addr)
          ADDR_CTL_A: rdata_reg <= ctl_a_reg;
          ADDR_CTL_B: rdata_reg <= ctl_b_reg;
          ADDR_CTL_C: rdata_reg <= {12'h000, start_reg};
          ADDR_PSEL: rdata_reg <= {4'h0, port_dig_disable_reg};
          ADDR_FLAG: rdata_reg <= flag_reg;
          ADDR_VEC: rdata_reg <= {10'h000, vec};
          ADDR_STAT: rdata_reg <= {9'h000, ptr_reg, tov_reg, ov_reg, busy_reg};
          default: rdata_reg <= REG_RST;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_no_start_off: assert property (@(posedge clk) disable iff (!rst_b) // RULE6
    (state_reg == ST_IDLE && !enc) |=> state_reg == ST_IDLE) else $error("conversion began while disabled");
  a_core_power: assert property (@(posedge clk) disable iff (!rst_b) // RULE4
    ##1 core_power_reg == $past(ctl_a_reg[CA_ON])) else $error("core power not following its bit");
  a_cfg_lock: assert property (@(posedge clk) disable iff (!rst_b) // RULE5
    (wr && enc && addr == ADDR_CTL_B) |=> $stable(ctl_b_reg)) else $error("locked config changed");
  a_mux_break: assert property (@(posedge clk) disable iff (!rst_b) // RULE12
    !$stable(mux_channel_reg) |-> !$past(mux_connect_reg) && !mux_connect_reg) else $error("switch made before break");
  a_pin_digital: assert property (@(posedge clk) disable iff (!rst_b) // RULE13
    (wr && addr == ADDR_PSEL) |=> port_dig_disable_reg == $past(wdata[NPIN-1:0])) else $error("pin select not applied");
  a_full_scale: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    (conv_done && nbits == 4'hC && hold_reg >= vrp_reg) |=> mem_reg[$past(ptr_reg)] == FULL_SCALE)
    else $error("full scale code missing");
  a_zero_code: assert property (@(posedge clk) disable iff (!rst_b) // RULE2
    (conv_done && hold_reg <= vrm_reg && hold_reg < vrp_reg) |=> mem_reg[$past(ptr_reg)] == 12'h000)
    else $error("zero code missing");
  a_result_pad: assert property (@(posedge clk) disable iff (!rst_b) // RULE19
    (rd && (addr & BLK_MASK) == ADDR_MEM) |=> rdata_reg[15:12] == 4'h0) else $error("result upper bits set");
  a_vec_order: assert property (@(posedge clk) disable iff (!rst_b) // RULE14
    (ov_reg || tov_reg) |-> vec == (ov_reg ? VEC_OV : VEC_TOV)) else $error("vector priority wrong");
  a_edge_start: assert property (@(posedge clk) disable iff (!rst_b) // RULE17
    start_go |=> state_reg == ST_SAMPLE ##1 sampling_reg) else $error("edge did not start sampling");
  a_conv_length: assert property (@(posedge clk) disable iff (!rst_b) // RULE18
    (state_reg == ST_CONVERT && tick && conv_cnt_reg == 4'h0) |-> nbits <= 4'hC) else $error("bad bit count");
  c_single: cover property (@(posedge clk) conv_done && mode == M_SINGLE);
  c_seq_wrap: cover property (@(posedge clk) conv_done && mode == M_REP_SEQ && mctl_reg[ptr_reg][ME_EOS]);
  c_overflow: cover property (@(posedge clk) conv_done && flag_reg[ptr_reg]);
  c_pulse: cover property (@(posedge clk) pulse_mode && state_reg == ST_SAMPLE ##1 state_reg == ST_CONVERT);
endmodule // sarc_ctrl

// ==== sarc_pkg.sv ====
// sarc_pkg: shared constants and types for the converter control block
// assumes one 250 MHz clock domain and a 16-bit plain register port
package sarc_pkg;
  localparam int DW = 16;
  localparam int RW = 12;
  localparam int NENT = 16;
  localparam int NCH = 16;
  localparam int NPIN = 12;
  localparam real CLK_MHZ = 250.0;
  // register byte offsets
  localparam logic [7:0] ADDR_CTL_A = 8'h00;
  localparam logic [7:0] ADDR_CTL_B = 8'h02;
  localparam logic [7:0] ADDR_CTL_C = 8'h04;
  localparam logic [7:0] ADDR_PSEL = 8'h06;
  localparam logic [7:0] ADDR_FLAG = 8'h08;
  localparam logic [7:0] ADDR_VEC = 8'h0A;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_MCTL = 8'h20;
  localparam logic [7:0] ADDR_MEM = 8'h40;
  localparam logic [7:0] BLK_MASK = 8'hE0;
  // control a fields
  localparam int CA_ON = 0;
  localparam int CA_ENC = 1;
  localparam int CA_SC = 2;
  localparam int CA_SHT = 4;
  localparam logic [15:0] CA_OPEN_MASK = 16'h0006;
  // control b fields
  localparam int CB_MODE = 0;
  localparam int CB_TRIG = 2;
  localparam int CB_SRC = 4;
  localparam int CB_DIV = 6;
  localparam int CB_PDIV = 9;
  localparam int CB_PULSE = 10;
  localparam int CB_RES = 11;
  // entry fields
  localparam int ME_CH = 0;
  localparam int ME_REFP = 4;
  localparam int ME_REFN = 5;
  localparam int ME_EOS = 7;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [RW-1:0] FULL_SCALE = 12'hFFF;
  localparam logic [RW-1:0] MSB_TRIAL = 12'h800;
  localparam logic [6:0] SHT_MULT = 7'h04;
  localparam logic [1:0] PREDIV_LAST = 2'h3;
  // six bits: entry 15 reports as 36
  localparam logic [5:0] VEC_NONE = 6'h00;
  localparam logic [5:0] VEC_OV = 6'h02;
  localparam logic [5:0] VEC_TOV = 6'h04;
  localparam logic [5:0] VEC_MEM0 = 6'h06;
  typedef enum logic [1:0] {M_SINGLE, M_REP_SINGLE, M_SEQ, M_REP_SEQ} sarc_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} sarc_state_t;
endpackage

// ==== sarc_clkdiv.sv ====
// sarc_clkdiv: conversion clock as a one-cycle tick from a selected source
// assumes source ticks are single-cycle pulses synchronous to clk
`timescale 1ns/10ps
module sarc_clkdiv (
  input wire logic clk, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic run, // counters held clear when low
  input wire logic [3:0] src_tick, // source clock ticks
  input wire logic [1:0] src_sel, // clock_source_select
  input wire logic prediv, // clock_predivide, /4 when set
  input wire logic [2:0] div, // clock_divider_field, ratio div+1
  output logic tick_reg // conversion_clock tick
);
  import sarc_pkg::*;
  logic [1:0] pre_cnt_reg;
  logic [2:0] div_cnt_reg;
  logic src_pulse;
  logic pre_pulse;
  // RULE9 source choice
  assign src_pulse = src_tick[src_sel];
  // RULE20 predivider first, then divider
  assign pre_pulse = src_pulse && (!prediv || pre_cnt_reg == PREDIV_LAST);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_reg <= 2'h0;
    end else if (!run || !prediv) begin
      pre_cnt_reg <= 2'h0;
    end else if (src_pulse) begin
      pre_cnt_reg <= pre_cnt_reg + 2'h1;
    end
  end
  // RULE8 ratio 1 to 32
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= run && pre_pulse && div_cnt_reg == div;
      if (!run || (pre_pulse && div_cnt_reg == div)) begin
        div_cnt_reg <= 3'h0;
      end else if (pre_pulse) begin
        div_cnt_reg <= div_cnt_reg + 3'h1;
      end
    end
  end
  a_div_ratio: assert property (@(posedge clk) disable iff (!rst_b)
    (run && !prediv && div == 3'h0 && src_pulse) |=> tick_reg) // RULE8
    else $error("undivided source tick not passed through");
endmodule // sarc_clkdiv

// ==== sarc_ctrl_tb.sv ====
// sarc_ctrl_tb: self-checking bench for the converter control block
// assumes the plain register port; source ticks and analog levels are made here
`timescale 1ns/10ps
module sarc_ctrl_tb;
  import sarc_pkg::*;
  typedef struct packed {
    logic [1:0] src; logic pd; logic [2:0] dv; logic [1:0] res; logic [1:0] trg;
    logic [3:0] ent; logic [3:0] ch; logic rp; logic rn; logic [11:0] vin; logic [11:0] exp;
  } sarc_row_t;
  logic clk, rst_b, wr, rd, prev_conn;
  logic [7:0] addr, cnt;
  logic [15:0] wdata, rdata_reg, cb, d;
  logic [3:0] src_tick, prev_ch, mux_channel_reg;
  logic [2:0] timer_trig;
  logic [NCH*RW-1:0] ana_in;
  logic [RW-1:0] ana [NCH];
  logic [RW-1:0] ref_pos_int, ref_pos_ext, ref_neg_ext;
  logic core_power_reg, mux_connect_reg, sampling_reg, busy_reg;
  logic [NPIN-1:0] port_dig_disable_reg;
  int miscompares, total_checks;
  // src, pd, div, res, trig, entry, channel, ext upper, ext lower, level, result
  sarc_row_t rows [6] = '{
    '{2'h0, 1'b0, 3'h0, 2'h2, 2'h0, 4'h0, 4'h3, 1'b0, 1'b0, 12'h5A3, 12'h5A3},
    '{2'h1, 1'b0, 3'h2, 2'h2, 2'h1, 4'hF, 4'hF, 1'b1, 1'b0, 12'h900, 12'hFFF},
    '{2'h2, 1'b1, 3'h0, 2'h0, 2'h2, 4'h7, 4'hB, 1'b0, 1'b0, 12'hFFF, 12'h0FF},
    '{2'h3, 1'b0, 3'h7, 2'h1, 2'h3, 4'h8, 4'hC, 1'b0, 1'b1, 12'h300, 12'h000},
    '{2'h0, 1'b1, 3'h7, 2'h2, 2'h0, 4'h1, 4'h0, 1'b1, 1'b1, 12'h800, 12'hFFF},
    '{2'h1, 1'b1, 3'h3, 2'h1, 2'h1, 4'h4, 4'h7, 1'b0, 1'b0, 12'h000, 12'h000}};
  sarc_ctrl sarc_ctrl_inst (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_reg(rdata_reg), .src_tick(src_tick), .timer_trig(timer_trig), .ana_in(ana_in),
    .ref_pos_int(ref_pos_int), .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext),
    .core_power_reg(core_power_reg), .mux_channel_reg(mux_channel_reg), .mux_connect_reg(mux_connect_reg),
    .sampling_reg(sampling_reg), .port_dig_disable_reg(port_dig_disable_reg), .busy_reg(busy_reg));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always_comb for (int i = 0; i < NCH; i++) ana_in[i*RW +: RW] = ana[i];
  // source periods of 1, 2, 4 and 8 cycles so a wrong source shows in timing
  // sources never stop
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
    src_tick <= {cnt[2:0] == 3'h7, cnt[1:0] == 2'h3, cnt[0], 1'b1};
  end
  // channel never moves while switch closed
  always @(posedge clk) begin
    if (rst_b === 1'b1 && prev_conn === 1'b1 && mux_channel_reg !== prev_ch) begin
      $display("CHECK FAILED mux_channel expected %h seen %h", prev_ch, mux_channel_reg);
      miscompares++;
    end
    prev_conn <= mux_connect_reg;
    prev_ch <= mux_channel_reg;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %0s expected %h seen %h", name, e, g);
      miscompares++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata_reg;
  endtask
  task automatic pollf(input logic [15:0] m);
    logic [15:0] f;
    int i;
    f = 16'h0000;
    i = 0;
    while ((f & m) !== m && i < 400) begin
      rreg(ADDR_FLAG, f);
      i++;
    end
    chk("flags", m, f & m);
  endtask
  task automatic conv(input sarc_row_t r);
    int n, k, tt;
    logic ok, okd;
    cb = {3'h0, r.res, 1'b1, r.pd, r.dv, r.src, r.trg, 2'h0};
    ana[r.ch] <= r.vin;
    wreg(ADDR_CTL_A, 16'h0001);
    wreg(ADDR_MCTL + {3'h0, r.ent, 1'b0}, {10'h000, r.rn, r.rp, r.ch});
    wreg(ADDR_CTL_B, cb);
    wreg(ADDR_CTL_C, {12'h000, r.ent});
    wreg(ADDR_CTL_A, 16'h0003);
    if (r.trg == 2'h0) wreg(ADDR_CTL_A, 16'h0007);
    else timer_trig[r.trg - 2'h1] <= 1'b1;
    n = 0;
    ok = 1'b1;
    while (busy_reg !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    timer_trig <= 3'h0;
    n = 1;
    while (busy_reg === 1'b1 && n < 9000) begin
      @(posedge clk);
      #1 n++;
      if (sampling_reg === 1'b1 && mux_channel_reg !== r.ch) ok = 1'b0;
    end
    // pulse sample 4 ticks, sync tick, then one tick per bit
    k = 5 + (r.res == 2'h0 ? 8 : r.res == 2'h1 ? 10 : 12);
    tt = (1 << r.src) * (r.pd ? 4 : 1) * (r.dv + 1);
    okd = n >= k * tt - tt - 4 && n <= k * tt + tt + 4;
    chk("busy span", 16'h0001, {15'h0, okd});
    chk("sampled channel", 16'h0001, {15'h0, ok});
    rreg(ADDR_VEC, d);
    chk("vector", 16'(6 + 2 * r.ent), d);
    rreg(ADDR_MEM + {3'h0, r.ent, 1'b0}, d);
    chk("result", {4'h0, r.exp}, d);
    rreg(ADDR_VEC, d);
    chk("vector cleared", 16'h0000, d);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(4 * 60000);
    miscompares++;
    stop_test();
  end
  initial begin
    {rst_b, wr, rd, addr, wdata, timer_trig, src_tick, cnt, prev_conn, prev_ch} = '0;
    for (int i = 0; i < NCH; i++) ana[i] = 12'h000;
    ref_pos_int = 12'hFFF;
    ref_pos_ext = 12'h800;
    ref_neg_ext = 12'h400;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk("outputs at reset", 16'h0000, {core_power_reg, busy_reg, sampling_reg, mux_connect_reg,
      port_dig_disable_reg});
    rreg(ADDR_CTL_B, d);
    chk("ctl_b reset", REG_RST, d);
    $display("test reset done");
    for (int i = 0; i < 6; i++) conv(rows[i]);
    $display("test conversion rows done");
    wreg(ADDR_CTL_B, 16'h0000);
    rreg(ADDR_CTL_B, d);
    chk("ctl_b locked", cb, d);
    wreg(ADDR_CTL_A, 16'h0001);
    wreg(ADDR_PSEL, 16'h0A5C);
    rreg(ADDR_PSEL, d);
    chk("pin select", 16'h0A5C, {4'h0, port_dig_disable_reg});
    chk("pin select readback", 16'h0A5C, d);
    wreg(8'h80, 16'hFFFF);
    rreg(8'h80, d);
    chk("unmapped", 16'h0000, d);
    // start bit without enable must stay idle
    wreg(ADDR_CTL_B, 16'h1400);
    wreg(ADDR_CTL_A, 16'h0005);
    repeat (40) @(posedge clk);
    chk("busy without enable", 16'h0000, {15'h0, busy_reg});
    $display("test interlock done");
    ana[1] <= 12'h111;
    ana[2] <= 12'h222;
    wreg(ADDR_CTL_A, 16'h0001);
    wreg(ADDR_MCTL + 8'h04, 16'h0001);
    wreg(ADDR_MCTL + 8'h06, 16'h0082);
    wreg(ADDR_CTL_C, 16'h0002);
    for (int m = 1; m < 4; m++) begin
      wreg(ADDR_CTL_A, 16'h0001);
      wreg(ADDR_CTL_B, 16'h1400 | 16'(m));
      wreg(ADDR_CTL_A, 16'h0003);
      wreg(ADDR_CTL_A, 16'h0007);
      pollf(16'h0004);
      // each entry of a sequence needs its own trigger edge
      if (m > 1) begin
        wreg(ADDR_CTL_A, 16'h0007);
        pollf(16'h000C);
      end
      rreg(ADDR_MEM + 8'h04, d);
      chk("entry 2 result", 16'h0111, d);
      rreg(ADDR_MEM + 8'h06, d);
      chk("entry 3 result", m > 1 ? 16'h0222 : 16'h0000, d);
      // repeat modes come round to the start entry, once modes stay locked
      wreg(ADDR_CTL_A, 16'h0007);
      repeat (60) @(posedge clk);
      rreg(ADDR_FLAG, d);
      chk("restart flags", m != 2 ? 16'h0004 : 16'h0000, d);
      wreg(ADDR_FLAG, 16'h000C);
    end
    wreg(ADDR_CTL_A, 16'h0001);
    // extended mode: sampling lasts while the timer level stays high
    wreg(ADDR_CTL_B, 16'h1004);
    wreg(ADDR_CTL_A, 16'h0003);
    timer_trig <= 3'h1;
    repeat (30) @(posedge clk);
    #1 chk("extended sample held", 16'h0001, {15'h0, sampling_reg});
    @(posedge clk);
    timer_trig <= 3'h0;
    pollf(16'h0004);
    rreg(ADDR_MEM + 8'h04, d);
    chk("extended result", 16'h0111, d);
    wreg(ADDR_CTL_A, 16'h0001);
    $display("test modes done");
    wreg(ADDR_CTL_A, 16'h0000);
    @(posedge clk);
    #1 chk("core power off", 16'h0000, {15'h0, core_power_reg});
    wreg(ADDR_CTL_A, 16'h0001);
    @(posedge clk);
    #1 chk("core power on", 16'h0001, {15'h0, core_power_reg});
    $display("test power done");
    stop_test();
  end
endmodule // sarc_ctrl_tb
